// [logic/eil_pin_sync.sv]
// Two-stage synchroniser with a combinational falling-edge detector for the request pin.
// Assumes the pin is asynchronous to clk_sys; the first stage feeds only the second.
`timescale 1ns/100ps
module eil_pin_sync (
    input  wire logic clk_sys,
    input  wire logic rst_n,
    input  wire logic pin_n,
    output logic      pin_level_n,
    output logic      pin_fall
);
    logic stage_a;
    logic stage_b;
    logic primed;

    // The chain keeps sampling through reset, so a pin held low across reset
    // is not mistaken for a fresh falling edge once reset is released.
    always_ff @(posedge clk_sys) begin
        stage_a     <= pin_n;
        stage_b     <= stage_a;
        pin_level_n <= stage_b;
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            primed <= 1'b0;
        end else begin
            primed <= 1'b1;
        end
    end

    assign pin_fall = primed & pin_level_n & ~stage_b;
endmodule

// [logic/eil_top.sv]
// External interrupt latch with its status/control register on a classic Wishbone slave.
// Assumes vector_fetch is a one-cycle pulse from the CPU and break_state a level from debug.
//
// The implementer's own choice: register access over Wishbone.
`timescale 1ns/100ps

module eil_top (
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    input  wire logic        irq_pin_n,
    input  wire logic        vector_fetch,
    input  wire logic        break_state,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic [31:0]      wb_dat_o,
    output logic             wb_ack_o,
    output logic             wb_err_o,
    output logic             cpu_request,
    output logic             irq_out
);
    // ------------------------------------------------------------------
    // Pin synchronisation
    // ------------------------------------------------------------------
    logic pin_level_n;
    logic pin_fall;

    eil_pin_sync u_sync (
        .clk_sys     (clk_sys),
        .rst_n       (rst_n),
        .pin_n       (irq_pin_n),
        .pin_level_n (pin_level_n),
        .pin_fall    (pin_fall)
    );

    // ------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------
    logic                              request;
    logic                              wr_strobe;
    logic                              hit_sc;
    logic                              hit_brk;
    logic                              hit_ist;
    logic                              hit_imk;
    logic                              mapped;
    logic                              sensitivity_select_bit;
    logic                              request_mask_bit;
    logic                              break_clear_enable;
    logic                              latch;
    logic                              ack_pending;
    logic                              sw_ack;
    logic                              any_ack;
    logic                              next_latch;
    logic                              next_ack_pending;
    logic [eil_pkg::NUM_EVENTS-1:0]    ev_status;
    logic [eil_pkg::NUM_EVENTS-1:0]    ev_mask;
    logic [eil_pkg::NUM_EVENTS-1:0]    ev_set;
    logic [31:0]                       next_rdata;

    assign request   = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
    assign wr_strobe = request & wb_we_i & wb_sel_i[0];

    always_comb begin
        hit_sc  = 1'b0;
        hit_brk = 1'b0;
        hit_ist = 1'b0;
        hit_imk = 1'b0;
        if (wb_adr_i == eil_pkg::ADDR_STATUS_CONTROL) begin
            hit_sc = 1'b1;
        end else if (wb_adr_i == eil_pkg::ADDR_BREAK_CONTROL) begin
            hit_brk = 1'b1;
        end else if (wb_adr_i == eil_pkg::ADDR_IRQ_STATUS) begin
            hit_ist = 1'b1;
        end else if (wb_adr_i == eil_pkg::ADDR_IRQ_MASK) begin
            hit_imk = 1'b1;
        end
    end

    assign mapped = hit_sc | hit_brk | hit_ist | hit_imk;

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            wb_ack_o <= 1'b0;
            wb_err_o <= 1'b0;
        end else begin
            wb_ack_o <= request & mapped;
            wb_err_o <= request & ~mapped;
        end
    end

    // ------------------------------------------------------------------
    // Control bits
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            sensitivity_select_bit <= eil_pkg::RESET_SENSITIVITY;
            request_mask_bit       <= eil_pkg::RESET_MASK;
        end else if (wr_strobe && hit_sc) begin
            sensitivity_select_bit <= wb_dat_i[eil_pkg::POS_SENSITIVITY];
            request_mask_bit       <= wb_dat_i[eil_pkg::POS_MASK];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            break_clear_enable <= eil_pkg::RESET_BREAK_CLEAR;
        end else if (wr_strobe && hit_brk) begin
            break_clear_enable <= wb_dat_i[eil_pkg::POS_BREAK_CLEAR];
        end
    end

    // ------------------------------------------------------------------
    // Interrupt latch
    // ------------------------------------------------------------------
    // A software acknowledge during break only counts when clearing is enabled.
    assign sw_ack  = wr_strobe & hit_sc & wb_dat_i[eil_pkg::POS_ACK]
                     & (~break_state | break_clear_enable);
    assign any_ack = sw_ack | vector_fetch;

    // In level mode an acknowledge seen while the pin is low is remembered
    // until the pin returns high, so either order of the two clears the latch.
    always_comb begin
        next_latch       = latch;
        next_ack_pending = ack_pending;
        if (!sensitivity_select_bit) begin
            next_ack_pending = 1'b0;
            if (any_ack) begin
                next_latch = 1'b0;
            end
        end else begin
            if (any_ack) begin
                next_ack_pending = 1'b1;
            end
            if ((any_ack || ack_pending) && pin_level_n) begin
                next_latch       = 1'b0;
                next_ack_pending = 1'b0;
            end
            if (!pin_level_n) begin
                next_latch = 1'b1;
            end
        end
        if (pin_fall) begin
            next_latch       = 1'b1;
            next_ack_pending = 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            latch       <= eil_pkg::RESET_LATCH;
            ack_pending <= 1'b0;
        end else begin
            latch       <= next_latch;
            ack_pending <= next_ack_pending;
        end
    end

    assign cpu_request = latch & ~request_mask_bit;

    // ------------------------------------------------------------------
    // Event status and mask
    // ------------------------------------------------------------------
    assign ev_set[eil_pkg::POS_EV_LATCH_SET]   = next_latch & ~latch;
    assign ev_set[eil_pkg::POS_EV_LATCH_CLEAR] = latch & ~next_latch;

    genvar gi;
    generate
        for (gi = 0; gi < eil_pkg::NUM_EVENTS; gi++) begin : g_event
            always_ff @(posedge clk_sys) begin
                if (!rst_n) begin
                    ev_status[gi] <= eil_pkg::RESET_EVENTS[gi];
                end else if (ev_set[gi]) begin
                    ev_status[gi] <= 1'b1;
                end else if (wr_strobe && hit_ist && wb_dat_i[gi]) begin
                    ev_status[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            ev_mask <= eil_pkg::RESET_EVENTS;
        end else if (wr_strobe && hit_imk) begin
            ev_mask <= wb_dat_i[eil_pkg::NUM_EVENTS-1:0];
        end
    end

    assign irq_out = |(ev_status & ev_mask);

    // ------------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------------
    always_comb begin
        next_rdata = 32'h0000_0000;
        if (hit_sc) begin
            next_rdata[eil_pkg::POS_PENDING]     = latch;
            next_rdata[eil_pkg::POS_ACK]         = 1'b0;
            next_rdata[eil_pkg::POS_MASK]        = request_mask_bit;
            next_rdata[eil_pkg::POS_SENSITIVITY] = sensitivity_select_bit;
        end else if (hit_brk) begin
            next_rdata[eil_pkg::POS_BREAK_CLEAR] = break_clear_enable;
        end else if (hit_ist) begin
            next_rdata[eil_pkg::NUM_EVENTS-1:0] = ev_status;
        end else if (hit_imk) begin
            next_rdata[eil_pkg::NUM_EVENTS-1:0] = ev_mask;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (request && !wb_we_i) begin
            wb_dat_o <= next_rdata;
        end
    end
endmodule

// [shared/eil_pkg.sv]
// Package for the external interrupt latch: register map, field positions and reset values.
// Assumes a classic Wishbone slave with 32-bit data, one aligned word per register.
package eil_pkg;
    // ------------------------------------------------------------------
    // Register indices and byte addresses
    // ------------------------------------------------------------------
    localparam logic [15:0] STATUS_CONTROL_INDEX = 16'h001a;
    localparam logic [7:0]  ADDR_STATUS_CONTROL  = 8'h68;
    localparam logic [7:0]  ADDR_BREAK_CONTROL   = 8'h80;
    localparam logic [7:0]  ADDR_IRQ_STATUS      = 8'h84;
    localparam logic [7:0]  ADDR_IRQ_MASK        = 8'h88;

    // ------------------------------------------------------------------
    // Status/control and break control field positions
    // ------------------------------------------------------------------
    localparam int POS_SENSITIVITY = 0;
    localparam int POS_MASK        = 1;
    localparam int POS_ACK         = 2;
    localparam int POS_PENDING     = 3;
    localparam int POS_BREAK_CLEAR = 0;

    // ------------------------------------------------------------------
    // Event status bits and reset values
    // ------------------------------------------------------------------
    localparam int POS_EV_LATCH_SET   = 0;
    localparam int POS_EV_LATCH_CLEAR = 1;
    localparam int NUM_EVENTS         = 2;
    localparam logic       RESET_SENSITIVITY = 1'b0;
    localparam logic       RESET_MASK        = 1'b0;
    localparam logic       RESET_BREAK_CLEAR = 1'b0;
    localparam logic       RESET_LATCH       = 1'b0;
    localparam logic [1:0] RESET_EVENTS      = 2'h0;
endpackage

// [test/eil_pin_source.sv]
// Far-side source that holds the request pin low on command.
// Assumes a pull-up on the pin, so a released pin reads high.
`timescale 1ns/100ps
module eil_pin_source (
    input  wire logic clk_sys,
    input  wire logic hold_low,
    output logic      irq_pin_n
);
    initial irq_pin_n = 1'b1;
    always @(posedge clk_sys) irq_pin_n <= ~hold_low;
endmodule

// [test/eil_top_props.sv]
// Checker on the ports of the external interrupt latch.
// Assumes it is bound to eil_top and sees one Wishbone request at a time.
`timescale 1ns/100ps
module eil_top_props (
    input wire logic        clk_sys,
    input wire logic        rst_n,
    input wire logic        irq_pin_n,
    input wire logic        vector_fetch,
    input wire logic        break_state,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [7:0]  wb_adr_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic        wb_err_o,
    input wire logic        cpu_request,
    input wire logic        irq_out
);
    logic tk, qt, sc, mk, md, rd_sc, s1, s2, s3, s4;
    assign tk = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
    assign sc = wb_adr_i == eil_pkg::ADDR_STATUS_CONTROL;
    assign qt = (irq_pin_n == s1) && (s1 == s2) && (s2 == s3) && (s3 == s4);
    always_ff @(posedge clk_sys) begin
        s1 <= irq_pin_n;
        s2 <= s1;
        s3 <= s2;
        s4 <= s3;
        rd_sc <= tk && !wb_we_i && sc;
    end
    // Shadow of the mask and sensitivity bits, written at the taking edge.
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            mk <= 1'b0;
            md <= 1'b0;
        end else if (tk && wb_we_i && wb_sel_i[0] && sc) begin
            mk <= wb_dat_i[1];
            md <= wb_dat_i[0];
        end
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    mask_gate_a: assert property (mk |-> !cpu_request)
        else $error("request shown while masked");
    fall_set_a: assert property ($fell(irq_pin_n) && !mk |-> ##[1:4] cpu_request)
        else $error("falling edge not latched");
    edge_clear_a: assert property (vector_fetch && !md && qt |=> !cpu_request)
        else $error("vector fetch did not clear");
    level_hold_a: assert property (md && qt && !s4 && cpu_request |=> cpu_request || mk)
        else $error("latch cleared while pin low");
    sc_read_a: assert property (wb_ack_o && rd_sc |-> wb_dat_o[31:4] == 28'h0
        && !wb_dat_o[2] && wb_dat_o[1] == mk && wb_dat_o[0] == md)
        else $error("status control read wrong");
    ack_answer_a: assert property (tk |=> wb_ack_o != wb_err_o)
        else $error("no single answer to request");
    ack_once_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    err_map_a: assert property (tk && !sc && wb_adr_i != eil_pkg::ADDR_BREAK_CONTROL
        && wb_adr_i != eil_pkg::ADDR_IRQ_STATUS && wb_adr_i != eil_pkg::ADDR_IRQ_MASK
        |=> wb_err_o)
        else $error("unmapped address not refused");
endmodule
bind eil_top eil_top_props eil_top_props_inst (.clk_sys, .rst_n, .irq_pin_n, .vector_fetch,
    .break_state, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o,
    .wb_ack_o, .wb_err_o, .cpu_request, .irq_out);

// [test/tb_external_interrupt_latch.sv]
// Self-checking bench for the external interrupt latch against a reference model.
// Assumes the pin source model and the bound checker.
`timescale 1ns/100ps
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin bad_count++; \
    $display("[ERR] %s exp %h got %h", n, e, g); end end
module tb_external_interrupt_latch;
    localparam logic [7:0] SC = eil_pkg::ADDR_STATUS_CONTROL;
    logic        clk_sys, rst_n, hold_low, vector_fetch, break_state, irq_pin_n, cc_int_mask;
    logic        wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, wb_err_o, cpu_request, irq_out, err;
    logic [7:0]  wb_adr_i;
    logic [31:0] wb_dat_i, wb_dat_o, rd;
    int          bad_count, cmp_count, seed, cyc_n, lat, msk, mde, ackd, low, brk;
    eil_top eil_top_inst (.clk_sys, .rst_n, .irq_pin_n, .vector_fetch, .break_state,
        .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i(4'hf), .wb_dat_i, .wb_dat_o,
        .wb_ack_o, .wb_err_o, .cpu_request, .irq_out);
    eil_pin_source eil_pin_source_inst (.clk_sys, .hold_low, .irq_pin_n);
    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end
    task automatic results();
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    always @(posedge clk_sys) begin
        cyc_n++;
        if (cyc_n == 20000) begin
            bad_count++;
            results();
        end
    end
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, we, a, d};
        do begin
            @(posedge clk_sys);
        end while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1);
        rd = wb_dat_o;
        err = wb_err_o;
        {wb_cyc_i, wb_stb_i} <= 2'b00;
    endtask
    task automatic sc_wr();
        wb(1'b1, SC, ($random(seed) & 32'hfffffff0) | (msk * 2) | mde);
    endtask
    // Acknowledge by software write or by a one-cycle vector fetch pulse.
    task automatic ack(input int sw);
        if (sw) wb(1'b1, SC, 32'h4 | (msk * 2) | mde);
        else begin
            @(posedge clk_sys);
            vector_fetch <= cpu_request & ~cc_int_mask;
            @(posedge clk_sys);
            vector_fetch <= 1'b0;
        end
        repeat (2) @(posedge clk_sys);
        if (!sw || !break_state || brk) begin
            if (mde && low) ackd = 1;
            else lat = 0;
        end
    endtask
    task automatic pin(input int l);
        @(posedge clk_sys);
        hold_low <= l[0];
        repeat (6) @(posedge clk_sys);
        if (l && !low) lat = 1;
        if (!l && ackd) lat = 0;
        if (!l) ackd = 0;
        low = l;
    endtask
    task automatic chk();
        wb(1'b0, SC, 32'h0);
        `CHK("status_control", 32'(lat * 8 + msk * 2 + mde), rd)
        `CHK("cpu_request", 1'(lat && !msk), cpu_request)
    endtask
    task automatic irq(input logic e);
        @(negedge clk_sys);
        `CHK("irq_out", e, irq_out)
    endtask
    initial begin
        seed = 60992;
        {rst_n, hold_low, vector_fetch, break_state, wb_cyc_i, wb_stb_i, wb_we_i} = 7'h0;
        cc_int_mask = 1'b0;
        {wb_adr_i, wb_dat_i} = 40'h0;
        repeat (10) @(posedge clk_sys);
        rst_n <= 1'b1;
        chk();
        wb(1'b0, eil_pkg::ADDR_BREAK_CONTROL, 32'h0);
        `CHK("break_control", 32'h0, rd)
        pin(1);
        chk();
        msk = 1;
        sc_wr();
        chk();
        msk = 0;
        sc_wr();
        ack(0);
        chk();
        pin(0);
        pin(1);
        ack(1);
        chk();
        pin(0);
        pin(1);
        chk();
        mde = 1;
        sc_wr();
        ack(0);
        chk();
        pin(0);
        chk();
        pin(1);
        pin(0);
        chk();
        msk = 1;
        sc_wr();
        ack(1);
        chk();
        mde = 0;
        msk = 0;
        sc_wr();
        pin(1);
        break_state <= 1'b1;
        ack(1);
        chk();
        wb(1'b1, eil_pkg::ADDR_BREAK_CONTROL, 32'h1);
        brk = 1;
        ack(1);
        chk();
        break_state <= 1'b0;
        chk();
        pin(0);
        wb(1'b1, eil_pkg::ADDR_IRQ_MASK, 32'h3);
        irq(1'b1);
        wb(1'b1, eil_pkg::ADDR_IRQ_STATUS, 32'h3);
        irq(1'b0);
        pin(1);
        irq(1'b1);
        wb(1'b1, eil_pkg::ADDR_IRQ_MASK, 32'h0);
        irq(1'b0);
        wb(1'b0, 8'h40, 32'h0);
        `CHK("unmapped_err", 1'b1, err)
        mde = 1;
        sc_wr();
        rst_n <= 1'b0;
        repeat (2) @(posedge clk_sys);
        rst_n <= 1'b1;
        {mde, msk, ackd, lat} = 128'h0;
        repeat (4) @(posedge clk_sys);
        chk();
        results();
    end
endmodule
